// file: eoc_pkg.sv
// Constants and types shared by the erase and OTP command engine.
package eoc_pkg;
    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OPC_WR_ENABLE    = 8'h06;
    localparam logic [7:0] OPC_WR_DISABLE   = 8'h04;
    localparam logic [7:0] OPC_RD_STATUS    = 8'h05;
    localparam logic [7:0] OPC_RD_FLAGS     = 8'h70;
    localparam logic [7:0] OPC_CLR_FLAGS    = 8'h50;
    localparam logic [7:0] OPC_ERASE_4K     = 8'h20;
    localparam logic [7:0] OPC_ERASE_32K    = 8'h52;
    localparam logic [7:0] OPC_ERASE_64K    = 8'hD8;
    localparam logic [7:0] OPC_ERASE_CHIP_A = 8'hC7;
    localparam logic [7:0] OPC_ERASE_CHIP_B = 8'h60;
    localparam logic [7:0] OPC_OTP_READ     = 8'h48;
    localparam logic [7:0] OPC_OTP_WRITE    = 8'h42;
    // ************************************************************
    // Register fields and reset values
    // ************************************************************
    localparam int         FS_READY_BIT     = 7;
    localparam int         FS_ERASE_ERR_BIT = 5;
    localparam int         FS_PROG_ERR_BIT  = 4;
    localparam int         FS_PROT_ERR_BIT  = 1;
    localparam int         VCR8_LOCK_EN_BIT = 2;
    localparam int         LOCK_BIT         = 0;
    localparam logic [7:0] FLAG_RESET       = 8'h80;
    localparam logic       OTP_LOCK_RESET   = 1'b1;
    localparam logic [8:0] OTP_LOCK_ADDR    = 9'h100;
    localparam logic [8:0] OTP_READ_STOP    = 9'h040;
    localparam logic [8:0] OTP_MAX_BYTES    = 9'h101;
    // ************************************************************
    // Frame byte counts and address geometry
    // ************************************************************
    localparam logic [9:0] CNT_CHIP_END     = 10'h001;
    localparam logic [9:0] CNT_STATUS_DATA  = 10'h001;
    localparam logic [9:0] CNT_ERASE_END    = 10'h004;
    localparam logic [9:0] CNT_OTP_DATA     = 10'h004;
    localparam logic [9:0] CNT_MAX          = 10'h3FF;
    localparam int         SHIFT_4K         = 12;
    localparam int         SHIFT_32K        = 15;
    localparam int         SHIFT_64K        = 16;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_MHZ                 = 100;
    localparam int          SUBSECTOR_ERASE_TIME_US = 50;
    localparam int          SECTOR_ERASE_TIME_US    = 100;
    localparam int          CHIP_ERASE_TIME_US      = 1000;
    localparam int          OTP_PROGRAM_TIME_US     = 3;
    localparam logic [31:0] OTP_PROG_CYC = 32'(OTP_PROGRAM_TIME_US * CLK_MHZ);
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {ES_4K, ES_32K, ES_64K, ES_CHIP} eoc_esize_t;
    typedef enum logic [1:0] {JOB_IDLE, JOB_ERASE, JOB_PROG} eoc_job_t;
endpackage

// file: eoc_engine.sv
// Erase and OTP command engine behind the serial memory pins.
// What this block does
// R01: Erase without write latch silently discarded.
// R02: Write latch stays set after any erase.
// R03: Host raises chip select after address.
// R04: Any address selects its whole region.
// R05: Late chip select: no erase, no flags.
// R06: Protected subsector: no erase, flags 1,5.
// R07: Erase busy in status, ready flag after.
// R08: Erase timeout sets flag bit 5.
// R09: Chip erase has opcode only, no address.
// R10: Decode 4K, 32K and 64K erase opcodes.
// R11: Both chip opcodes; refused if any protection.
// R12: Address bits sampled on rising clock.
// R13: OTP read increments, then sticks at 40h.
// R14: OTP write needs write latch set.
// R15: OTP write keeps at most 257 bytes.
// R16: OTP write busy; latch never cleared.
// R17: Chip select rise starts OTP programming.
// R18: Flag status bit 7 reports OTP done.
// R19: Control byte 256 bit 0 locks array.
// R20: Lock sticks; locked write sets flags 1,4.
// R21: Config 8 bit 2 low overrides lock.
// R22: Recovery sequence unlocks the OTP area.
// R23: Region base drops low address bits.
`timescale 1ns/1ns
module eoc_engine
    import eoc_pkg::*;
#(
    parameter logic [31:0] SSE_LIMIT_CYC = 32'(SUBSECTOR_ERASE_TIME_US * CLK_MHZ),
    parameter logic [31:0] SE_LIMIT_CYC  = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ),
    parameter logic [31:0] CE_LIMIT_CYC  = 32'(CHIP_ERASE_TIME_US * CLK_MHZ)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe,
    input  wire logic [7:0]  vol_cfg8,
    input  wire logic [15:0] protect_map,
    input  wire logic        recovery_req,
    input  wire logic        erase_done,
    output logic             erase_start,
    output eoc_esize_t       erase_size,
    output logic [23:0]      erase_base,
    output logic             busy_writing_flag,
    output logic             write_latch_flag,
    output logic [7:0]       flag_status,
    output logic             otp_lock_bit
);
    // ************************************************************
    // Link domain
    // ************************************************************
    // Chip select high holds the link logic except rx_byte_r and rx_tgl_r in reset, so every frame starts clean.
    logic       link_rst_n;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic [7:0] rx_byte_r;
    logic       rx_tgl_r;
    logic [6:0] tx_sh_r;
    logic [7:0] tx_byte_r;
    logic       tx_en_r;

    assign link_rst_n = rst_n & ~cs_n;

    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= {shift_r[5:0], si}; // [R12]
        end
    end

    // The byte stays stable for a whole byte time, which covers the toggle sync.
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte_r <= 8'h00;
            rx_tgl_r  <= 1'b0;
        end else if (bit_cnt_r == 3'h7) begin
            rx_byte_r <= {shift_r, si};
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end

    // Output byte is loaded at a byte boundary, one byte after it was prepared.
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so      <= 1'b0;
            so_oe   <= 1'b0;
            tx_sh_r <= 7'h00;
        end else if (bit_cnt_r == 3'h0) begin
            so      <= tx_byte_r[7];
            so_oe   <= tx_en_r;
            tx_sh_r <= tx_byte_r[6:0];
        end else begin
            so      <= tx_sh_r[6];
            tx_sh_r <= {tx_sh_r[5:0], 1'b0};
        end
    end

    // ************************************************************
    // Crossing into the system clock
    // ************************************************************
    logic [2:0] rx_sync_r;
    logic [3:0] cs_sync_r;
    logic       byte_evt;
    logic       frame_start;
    logic       frame_end;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_r <= 3'h0;
            cs_sync_r <= 4'hF;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rx_tgl_r};
            cs_sync_r <= {cs_sync_r[2:0], cs_n};
        end
    end

    // Frame end looks one stage later so the last byte is always counted first.
    assign byte_evt    = rx_sync_r[2] ^ rx_sync_r[1];
    assign frame_start = ~cs_sync_r[1] & cs_sync_r[2];
    assign frame_end   = cs_sync_r[2] & ~cs_sync_r[3];

    // ************************************************************
    // Command capture
    // ************************************************************
    logic [9:0]  cnt_r;
    logic [7:0]  cmd_r;
    logic [23:0] addr_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 10'h000;
        end else if (frame_start) begin
            cnt_r <= 10'h000;
        end else if (byte_evt && cnt_r != CNT_MAX) begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r  <= 8'h00;
            addr_r <= 24'h000000;
        end else if (byte_evt && cnt_r == 10'h000) begin
            cmd_r <= rx_byte_r;
        end else if (byte_evt && cnt_r < CNT_ERASE_END) begin
            addr_r <= {addr_r[15:0], rx_byte_r};
        end
    end

    // ************************************************************
    // Decode of a finished frame
    // ************************************************************
    eoc_job_t    job_r;
    logic        idle;
    logic        is_sect;
    logic        is_chip;
    logic        sect_ok;
    logic        chip_ok;
    logic        prog_ok;
    logic        sect_prot;
    logic        lock_eff;
    logic        go_erase;
    logic        go_prog;
    logic        timeout;
    logic        erase_fin;
    logic        prog_fin;
    logic [31:0] timer_r;
    logic [31:0] limit;
    logic [8:0]  wr_n_r;
    logic [8:0]  wr_idx_r;

    assign idle    = (job_r == JOB_IDLE);
    assign is_sect = cmd_r == OPC_ERASE_4K || cmd_r == OPC_ERASE_32K
                     || cmd_r == OPC_ERASE_64K; // [R10]
    assign is_chip = cmd_r == OPC_ERASE_CHIP_A || cmd_r == OPC_ERASE_CHIP_B; // [R11]
    assign sect_ok = frame_end && is_sect && cnt_r == CNT_ERASE_END
                     && write_latch_flag && idle; // [R01] [R03] [R05]
    assign chip_ok = frame_end && is_chip && cnt_r == CNT_CHIP_END
                     && write_latch_flag && idle; // [R01] [R09]
    assign prog_ok = frame_end && cmd_r == OPC_OTP_WRITE && cnt_r > CNT_OTP_DATA
                     && write_latch_flag && idle; // [R14] [R15] [R17]
    assign sect_prot = protect_map[addr_r[SHIFT_64K+3:SHIFT_64K]]; // [R06]
    assign lock_eff  = !otp_lock_bit && vol_cfg8[VCR8_LOCK_EN_BIT]; // [R19] [R21]
    assign go_erase  = (sect_ok && !sect_prot) || (chip_ok && protect_map == 16'h0000);
    assign go_prog   = prog_ok && !lock_eff;

    always_comb begin
        limit = SSE_LIMIT_CYC;
        if (erase_size == ES_64K) begin
            limit = SE_LIMIT_CYC;
        end else if (erase_size == ES_CHIP) begin
            limit = CE_LIMIT_CYC;
        end
    end

    assign timeout   = job_r == JOB_ERASE && !erase_done && timer_r >= limit - 32'h1;
    assign erase_fin = job_r == JOB_ERASE && (erase_done || timeout);
    assign prog_fin  = job_r == JOB_PROG && timer_r >= OTP_PROG_CYC - 32'h1
                       && wr_idx_r >= wr_n_r;

    // ************************************************************
    // Self-timed job and its status
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            job_r   <= JOB_IDLE;
            timer_r <= 32'h0;
        end else begin
            unique case (job_r)
                JOB_IDLE: begin
                    timer_r <= 32'h0;
                    if (go_erase) begin
                        job_r <= JOB_ERASE;
                    end else if (go_prog) begin
                        job_r <= JOB_PROG; // [R17]
                    end
                end
                JOB_ERASE: begin
                    timer_r <= timer_r + 32'h1;
                    if (erase_fin) begin
                        job_r <= JOB_IDLE;
                    end
                end
                JOB_PROG: begin
                    timer_r <= timer_r + 32'h1;
                    if (prog_fin) begin
                        job_r <= JOB_IDLE;
                    end
                end
                default: job_r <= JOB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_writing_flag <= 1'b0;
        end else if (go_erase || go_prog) begin
            busy_writing_flag <= 1'b1; // [R07] [R16]
        end else if (erase_fin || prog_fin) begin
            busy_writing_flag <= 1'b0;
        end
    end

    // Only the write-disable command clears the latch; jobs never touch it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch_flag <= 1'b0;
        end else if (frame_end && idle && cnt_r == CNT_CHIP_END) begin
            if (cmd_r == OPC_WR_ENABLE) begin
                write_latch_flag <= 1'b1;
            end else if (cmd_r == OPC_WR_DISABLE) begin
                write_latch_flag <= 1'b0; // [R02] [R16]
            end
        end
    end

    // Sets come after the clear so an error in the same cycle is kept.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_status <= FLAG_RESET;
        end else begin
            if (frame_end && idle && cmd_r == OPC_CLR_FLAGS) begin
                flag_status[FS_ERASE_ERR_BIT] <= 1'b0;
                flag_status[FS_PROG_ERR_BIT]  <= 1'b0;
                flag_status[FS_PROT_ERR_BIT]  <= 1'b0;
            end
            if ((sect_ok && sect_prot) || (chip_ok && protect_map != 16'h0000)) begin
                flag_status[FS_ERASE_ERR_BIT] <= 1'b1; // [R06] [R11]
                flag_status[FS_PROT_ERR_BIT]  <= 1'b1;
            end
            if (prog_ok && lock_eff) begin
                flag_status[FS_PROG_ERR_BIT] <= 1'b1; // [R20]
                flag_status[FS_PROT_ERR_BIT] <= 1'b1;
            end
            if (timeout) begin
                flag_status[FS_ERASE_ERR_BIT] <= 1'b1; // [R08]
            end
            if (go_erase || go_prog) begin
                flag_status[FS_READY_BIT] <= 1'b0; // [R07]
            end else if (erase_fin || prog_fin) begin
                flag_status[FS_READY_BIT] <= 1'b1; // [R07] [R18]
            end
        end
    end

    // ************************************************************
    // Erase request towards the array
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_start <= 1'b0;
            erase_size  <= ES_4K;
            erase_base  <= 24'h000000;
        end else begin
            erase_start <= go_erase;
            if (go_erase && is_chip) begin
                erase_size <= ES_CHIP;
                erase_base <= 24'h000000;
            end else if (go_erase && cmd_r == OPC_ERASE_64K) begin
                erase_size <= ES_64K;
                erase_base <= addr_r & ~((24'h000001 << SHIFT_64K) - 24'h000001); // [R04] [R23]
            end else if (go_erase && cmd_r == OPC_ERASE_32K) begin
                erase_size <= ES_32K;
                erase_base <= addr_r & ~((24'h000001 << SHIFT_32K) - 24'h000001); // [R04] [R23]
            end else if (go_erase) begin
                erase_size <= ES_4K;
                erase_base <= addr_r & ~((24'h000001 << SHIFT_4K) - 24'h000001); // [R04] [R23]
            end
        end
    end

    // ************************************************************
    // OTP staging, commit and lock
    // ************************************************************
    // Bytes are staged during the frame and committed only after chip select rises.
    logic [7:0] stage_mem [0:256];
    logic [7:0] otp_mem   [0:255];
    logic [9:0] data_idx;
    logic [9:0] tgt;

    assign data_idx = cnt_r - CNT_OTP_DATA;
    assign tgt      = {1'b0, addr_r[8:0]} + {1'b0, wr_idx_r};

    always_ff @(posedge clk) begin
        if (byte_evt && idle && cmd_r == OPC_OTP_WRITE && cnt_r >= CNT_OTP_DATA
            && data_idx < {1'b0, OTP_MAX_BYTES}) begin
            stage_mem[data_idx[8:0]] <= rx_byte_r; // [R15]
        end
        if (job_r == JOB_PROG && wr_idx_r < wr_n_r && tgt < {1'b0, OTP_LOCK_ADDR}) begin
            otp_mem[tgt[7:0]] <= stage_mem[wr_idx_r];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_n_r   <= 9'h000;
            wr_idx_r <= 9'h000;
        end else if (go_prog) begin
            wr_idx_r <= 9'h000;
            wr_n_r   <= (data_idx > {1'b0, OTP_MAX_BYTES}) ? OTP_MAX_BYTES
                        : data_idx[8:0]; // [R15]
        end else if (job_r == JOB_PROG && wr_idx_r < wr_n_r) begin
            wr_idx_r <= wr_idx_r + 9'h001;
        end
    end

    // The lock only ever moves towards locked, except through recovery.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_lock_bit <= OTP_LOCK_RESET;
        end else if (recovery_req) begin
            otp_lock_bit <= OTP_LOCK_RESET; // [R22]
        end else if (job_r == JOB_PROG && wr_idx_r < wr_n_r && tgt == {1'b0, OTP_LOCK_ADDR}) begin
            otp_lock_bit <= otp_lock_bit & stage_mem[wr_idx_r][LOCK_BIT]; // [R19] [R20]
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // One dummy byte precedes read data, to give the crossing time to settle.
    // The address is taken with its last byte, so the first data byte already comes from it.
    logic [8:0] rd_addr_r;
    logic       rd_step;

    assign rd_step = byte_evt && cmd_r == OPC_OTP_READ && cnt_r >= CNT_OTP_DATA;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_r <= 9'h000;
        end else if (byte_evt && cmd_r == OPC_OTP_READ && cnt_r == CNT_OTP_DATA - 10'h001) begin
            rd_addr_r <= {addr_r[0], rx_byte_r}; // [R13]
        end else if (rd_step && rd_addr_r < OTP_READ_STOP) begin
            rd_addr_r <= rd_addr_r + 9'h001; // [R13]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_r <= 8'h00;
            tx_en_r   <= 1'b0;
        end else if (cmd_r == OPC_RD_STATUS) begin
            tx_byte_r <= {6'h00, write_latch_flag, busy_writing_flag};
            tx_en_r   <= cnt_r >= CNT_STATUS_DATA;
        end else if (cmd_r == OPC_RD_FLAGS) begin
            tx_byte_r <= flag_status; // [R18]
            tx_en_r   <= cnt_r >= CNT_STATUS_DATA;
        end else if (cmd_r == OPC_OTP_READ) begin
            tx_byte_r <= (rd_addr_r == OTP_LOCK_ADDR) ? {7'h00, otp_lock_bit}
                         : otp_mem[rd_addr_r[7:0]]; // [R19]
            tx_en_r   <= cnt_r >= CNT_OTP_DATA;
        end else begin
            tx_byte_r <= 8'h00;
            tx_en_r   <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_busy_start;
        busy_writing_flag && !flag_status[FS_READY_BIT];
    endsequence
    sequence s_refused;
        !busy_writing_flag && write_latch_flag && flag_status[FS_PROT_ERR_BIT];
    endsequence

    AST_NO_LATCH: assert property (frame_end && (is_sect || is_chip) && !write_latch_flag // [R01]
        |=> !busy_writing_flag && !$rose(flag_status[FS_ERASE_ERR_BIT]))
        else $error("Erase ran without write latch.");
    AST_LATCH_KEPT: assert property (busy_writing_flag |-> write_latch_flag) // [R02]
        else $error("Write latch lost during a job.");
    AST_LATE_CS: assert property (frame_end && is_sect && cnt_r != CNT_ERASE_END // [R05]
        |=> !erase_start && !$rose(flag_status[FS_PROT_ERR_BIT]))
        else $error("Erase ran with bad framing.");
    AST_PROT_SECT: assert property (sect_ok && sect_prot // [R06]
        |=> s_refused and flag_status[FS_ERASE_ERR_BIT] && !erase_start)
        else $error("Protected subsector not refused.");
    AST_PROT_CHIP: assert property (chip_ok && protect_map != 16'h0000 // [R11]
        |=> s_refused and flag_status[FS_ERASE_ERR_BIT])
        else $error("Chip erase not refused.");
    AST_ERASE_RUN: assert property (go_erase |=> s_busy_start and erase_start) // [R07]
        else $error("Erase start not shown.");
    AST_ERASE_END: assert property (erase_fin // [R07]
        |=> !busy_writing_flag && flag_status[FS_READY_BIT] && write_latch_flag)
        else $error("Erase end not shown.");
    AST_TIMEOUT: assert property (timeout |=> flag_status[FS_ERASE_ERR_BIT]) // [R08]
        else $error("Timeout flag missing.");
    AST_BASE: assert property (erase_start && erase_size == ES_4K // [R23]
        |-> erase_base[SHIFT_4K-1:0] == 12'h000)
        else $error("Subsector base not aligned.");
    AST_RD_STOP: assert property (rd_step && rd_addr_r == OTP_READ_STOP // [R13]
        |=> rd_addr_r == OTP_READ_STOP)
        else $error("OTP read moved past stop.");
    AST_PROG_RUN: assert property (go_prog |=> s_busy_start ##1 busy_writing_flag[*8]) // [R16]
        else $error("OTP programming too short.");
    AST_LOCK_STICKY: assert property (!otp_lock_bit && !recovery_req |=> !otp_lock_bit) // [R20]
        else $error("Lock bit returned to one.");
    AST_PROG_LOCKED: assert property (prog_ok && lock_eff // [R20]
        |=> s_refused and flag_status[FS_PROG_ERR_BIT])
        else $error("Locked OTP write not refused.");
    AST_STAGE_MAX: assert property (go_prog |=> wr_n_r <= OTP_MAX_BYTES) // [R15]
        else $error("Too many OTP bytes kept.");
endmodule

// file: eoc_host.sv
// Serial host model that frames commands on the link clock.
`timescale 1ns/1ns
module eoc_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // The link clock stands still between frames, and the data line toggles so stale bits show.
    task automatic op(input logic [7:0] q[$], input int nrd, output logic [7:0] rd);
        logic [7:0] b;
        rd = 8'h00;
        cs_n = 1'b0;
        #7;
        for (int i = 0; i < q.size() + nrd; i++) begin
            b = (i < q.size()) ? q[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                si = b[k];
                #7 sck = 1'b1;
                rd = {rd[6:0], so};
                #8 sck = 1'b0;
            end
        end
        #7 cs_n = 1'b1;
        si = ~si;
        #60;
    endtask
endmodule

// file: eoc_engine_tb.sv
// Self-checking bench for the erase and OTP command engine.
`timescale 1ns/1ns
module eoc_engine_tb;
    import eoc_pkg::*;
    logic       clk, rst_n, sck, cs_n, si, so, so_oe, recovery_req, erase_done, erase_start;
    logic       busy_writing_flag, write_latch_flag, otp_lock_bit;
    logic [7:0] vol_cfg8, flag_status, rd;
    logic [15:0] protect_map;
    logic [23:0] erase_base;
    eoc_esize_t erase_size;
    int         err_total, samples_checked, cyc, hits;
    logic       oe_seen = 1'b0;
    logic [7:0] opt [5] = '{OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K, 8'hC7, 8'h60};
    logic [23:0] bse [3] = '{24'h0AB000, 24'h0A8000, 24'h0A0000};
    eoc_engine #(.SSE_LIMIT_CYC(32'h32), .SE_LIMIT_CYC(32'h64), .CE_LIMIT_CYC(32'hC8))
    u_eoc_engine (.clk, .rst_n, .sck, .cs_n, .si, .so, .so_oe, .vol_cfg8, .protect_map,
        .recovery_req, .erase_done, .erase_start, .erase_size, .erase_base,
        .busy_writing_flag, .write_latch_flag, .flag_status, .otp_lock_bit);
    eoc_host u_eoc_host (.sck, .cs_n, .si, .so);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge sck) if (so_oe === 1'b1) oe_seen = 1'b1;
    always @(posedge clk) begin
        cyc++;
        if (erase_start === 1'b1) hits++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] q[$]);
        u_eoc_host.op(q, 0, rd);
        go(8);
    endtask
    task automatic done_pulse;
        erase_done = 1'b1;
        go(1);
        erase_done = 1'b0;
        go(2);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {rst_n, recovery_req, erase_done, hits, cyc, err_total, samples_checked} = '0;
        vol_cfg8 = 8'hFF;
        protect_map = 16'h0000;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        go(4);
        chk("flags", flag_status, 8'h80);
        chk("lock", otp_lock_bit, 1'b1);
        cmd('{OPC_ERASE_64K, 8'h01, 8'h00, 8'h00});
        chk("starts", hits, 0);
        chk("flags", flag_status, 8'h80);
        $display("test 1 done");
        cmd('{OPC_WR_ENABLE});
        for (int i = 0; i < 5; i++) begin
            if (i < 3) cmd('{opt[i], 8'h0A, 8'hBC, 8'hDE});
            else cmd('{opt[i]});
            chk("size", erase_size, (i < 3) ? i : 3);
            if (i < 3) chk("base", erase_base, bse[i]);
            chk("busy", {busy_writing_flag, flag_status}, 9'h100);
            done_pulse;
            chk("done", {busy_writing_flag, write_latch_flag, flag_status}, 10'h180);
        end
        cmd('{OPC_ERASE_4K, 8'h00, 8'h10, 8'h00});
        go(70);
        chk("timeout", flag_status, 8'hA0);
        cmd('{OPC_CLR_FLAGS});
        protect_map = 16'h0004;
        cmd('{OPC_ERASE_64K, 8'h02, 8'h00, 8'h00});
        cmd('{8'hC7});
        chk("prot", {hits[7:0], write_latch_flag, flag_status}, {8'h6, 1'b1, 8'hA2});
        cmd('{OPC_CLR_FLAGS});
        protect_map = 16'h0000;
        cmd('{OPC_ERASE_64K, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("late", {hits[7:0], flag_status}, {8'h6, 8'h80});
        chk("oe_idle", oe_seen, 1'b0);
        $display("test 2 done");
        cmd('{OPC_WR_DISABLE});
        cmd('{OPC_OTP_WRITE, 8'h00, 8'h00, 8'h3F, 8'hAA});
        chk("nolatch", busy_writing_flag, 1'b0);
        cmd('{OPC_WR_ENABLE});
        cmd('{OPC_OTP_WRITE, 8'h00, 8'h00, 8'h3F, 8'hAA, 8'h55});
        chk("otpbusy", busy_writing_flag, 1'b1);
        go(300);
        u_eoc_host.op('{OPC_RD_FLAGS}, 2, rd);
        chk("ready", {busy_writing_flag, write_latch_flag, rd}, 10'h180);
        chk("oe_read", oe_seen, 1'b1);
        u_eoc_host.op('{OPC_OTP_READ, 8'h00, 8'h00, 8'h3F}, 4, rd);
        chk("otprd", rd, 8'h55);
        u_eoc_host.op('{OPC_OTP_READ, 8'h00, 8'h00, 8'h3F}, 2, rd);
        chk("otpfirst", rd, 8'hAA);
        cmd('{OPC_OTP_WRITE, 8'h00, 8'h01, 8'h00, 8'h00});
        go(300);
        u_eoc_host.op('{OPC_OTP_READ, 8'h00, 8'h01, 8'h00}, 2, rd);
        chk("lockrd", {otp_lock_bit, rd}, 9'h000);
        cmd('{OPC_OTP_WRITE, 8'h00, 8'h00, 8'h3F, 8'h11});
        go(300);
        chk("locked", {write_latch_flag, flag_status}, 9'h192);
        cmd('{OPC_CLR_FLAGS});
        vol_cfg8 = 8'hFB;
        cmd('{OPC_OTP_WRITE, 8'h00, 8'h00, 8'h3F, 8'h11});
        go(300);
        vol_cfg8 = 8'hFF;
        u_eoc_host.op('{OPC_OTP_READ, 8'h00, 8'h00, 8'h3F}, 2, rd);
        chk("override", {flag_status, rd}, 16'h8011);
        recovery_req = 1'b1;
        go(1);
        recovery_req = 1'b0;
        go(3);
        chk("recover", otp_lock_bit, 1'b1);
        $display("test 3 done");
        stop_test;
    end
endmodule
